// [shared/flash_host_pkg.sv]
// Constants and carrier types for the parallel flash host controller.
// Assumes a word-wide asynchronous flash on the far side of the pins.
package flash_host_pkg;
  // ==========================================================
  // Command bytes
  localparam logic [7:0] CMD_SUSPEND     = 8'hB0;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
  localparam logic [7:0] CMD_RESUME      = 8'hD0;
  localparam logic [7:0] CMD_READ_QUERY  = 8'h98;
  localparam logic [7:0] CMD_READ_CONFIG = 8'h90;
  // ==========================================================
  // Status and block status fields
  localparam int SR_READY_BIT   = 7;
  localparam int SR_SUSP_BIT    = 2;
  localparam int BSR_LOCK_BIT   = 0;
  localparam int BSR_LDOWN_BIT  = 1;
  localparam logic [5:0] BSR_RSVD_ZERO = 6'h00;
  localparam logic [7:0] QUERY_HI_ZERO = 8'h00;
  // ==========================================================
  // Query space layout
  localparam logic [21:0] QRY_ID_BASE   = 22'h000010;
  localparam logic [21:0] QRY_SYS_BASE  = 22'h00001B;
  localparam logic [21:0] QRY_RSVD_LO   = 22'h000004;
  localparam logic [21:0] QRY_RSVD_HI   = 22'h00000F;
  localparam logic [21:0] QRY_PTR_OFS   = 22'h000015;
  localparam logic [21:0] BSR_OFS       = 22'h000002;
  localparam logic [7:0]  QRY_CHAR_Q    = 8'h51;
  localparam logic [7:0]  QRY_CHAR_R    = 8'h52;
  localparam logic [7:0]  QRY_CHAR_Y    = 8'h59;
  localparam logic [21:0] BLOCK_WORDS   = 22'h008000;
  // ==========================================================
  // Bus timing (ns) and cycles at 10 MHz
  localparam int CLK_NS     = 100;
  localparam int T_STROBE_NS = 100;
  localparam int T_ACC_NS    = 70;
  localparam int STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC    = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  // ==========================================================
  // User-side orders
  typedef enum logic [2:0] {
    OP_SUSPEND,
    OP_RESUME,
    OP_READ_ARRAY,
    OP_READ_QUERY,
    OP_READ_BSR,
    OP_READ_STATUS
  } op_t;

  typedef struct packed {
    op_t         op;
    logic [21:0] addr;
  } req_t;

  typedef struct packed {
    logic [15:0] data;
    logic        ready;
    logic        suspended;
    logic        locked;
    logic        lockedDown;
    logic        queryOk;
  } resp_t;
endpackage

// [design/flash_host_ctrl.sv]
// Host controller driving an asynchronous word-wide flash over its pins.
// Assumes pins are in another timing domain; read data is synchronised.
// ==========================================================
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int ADDR_W = 22
)(
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic              clkEn,
  input  wire logic              reqValid,
  input  wire req_t              req,
  output logic                   reqReady,
  output logic                   respValid,
  output resp_t                  resp,
  output logic                   suspendRefused,
  output logic [ADDR_W-1:0]      flashAddr,
  input  wire logic [15:0]       flashDqIn,
  output logic [15:0]            flashDqOut,
  output logic                   flashDqOe,
  output logic                   flashCeN,
  output logic                   flashOeN,
  output logic                   flashWeN
);
  // ==========================================================
  // Sequencer
  typedef enum logic [2:0] { S_IDLE, S_WR, S_WRGAP, S_RD, S_SAMP, S_DONE } state_t;

  state_t             state_q;
  op_t                op_q;
  logic [ADDR_W-1:0]  addr_q;
  logic [1:0]         step_q;
  logic [1:0]         nSteps_q;
  logic [3:0]         cnt_q;
  logic [15:0]        sync1_q;
  logic [15:0]        sync2_q;
  logic [21:0]        suspBlock_q;
  logic               suspActive_q;
  logic               waitRd_q;

  function automatic logic [7:0] cmdFor(op_t o, logic [1:0] s);
    case (o)
      OP_SUSPEND:     cmdFor = (s == 2'd0) ? CMD_SUSPEND : CMD_READ_STATUS;
      OP_RESUME:      cmdFor = CMD_RESUME;
      OP_READ_ARRAY:  cmdFor = CMD_READ_ARRAY;
      OP_READ_QUERY:  cmdFor = CMD_READ_QUERY;
      OP_READ_BSR:    cmdFor = CMD_READ_CONFIG;
      default:        cmdFor = CMD_READ_STATUS;
    endcase
  endfunction

  function automatic logic [21:0] blockOf(logic [21:0] a);
    blockOf = a & ~(BLOCK_WORDS - 22'h000001);
  endfunction

  // Same-block array reads refused while a program is parked
  logic refuse;
  assign refuse = suspActive_q && req.op == OP_READ_ARRAY
                  && blockOf(req.addr) == suspBlock_q;
  assign reqReady = clkEn && state_q == S_IDLE;
  assign suspendRefused = reqValid && reqReady && refuse;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q  <= S_IDLE;
      op_q     <= OP_READ_STATUS;
      addr_q   <= '0;
      step_q   <= 2'd0;
      nSteps_q <= 2'd0;
      cnt_q    <= 4'h0;
      waitRd_q <= 1'b0;
    end
    else if (clkEn)
    begin
      case (state_q)
        S_IDLE:
          if (reqValid && !refuse)
          begin
            op_q     <= req.op;
            step_q   <= 2'd0;
            nSteps_q <= (req.op == OP_SUSPEND) ? 2'd2 : 2'd1;
            cnt_q    <= 4'h0;
            // Block status word sits two words past the block base
            addr_q   <= (req.op == OP_READ_BSR)
                        ? ADDR_W'(blockOf(req.addr) + BSR_OFS)
                        : ADDR_W'(req.addr);
            state_q  <= S_WR;
          end
        S_WR:
          if (cnt_q == 4'(STROBE_CYC - 1))
          begin
            cnt_q   <= 4'h0;
            state_q <= S_WRGAP;
          end
          else
            cnt_q <= cnt_q + 4'h1;
        S_WRGAP:
          if (step_q + 2'd1 < nSteps_q)
          begin
            step_q  <= step_q + 2'd1;
            state_q <= S_WR;
          end
          else if (op_q == OP_RESUME || op_q == OP_READ_ARRAY)
            state_q <= S_DONE;
          else
            state_q <= S_RD;
        S_RD:
          // Sync stages add two cycles on top of access time
          if (cnt_q == 4'(ACC_CYC + 2))
          begin
            cnt_q   <= 4'h0;
            state_q <= S_SAMP;
          end
          else
            cnt_q <= cnt_q + 4'h1;
        S_SAMP:
          // Poll with a fresh output-enable pulse until ready
          if (op_q == OP_SUSPEND && !sync2_q[SR_READY_BIT])
            state_q <= S_RD;
          else
            state_q <= S_DONE;
        S_DONE:
          state_q <= S_IDLE;
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Pin drive
  always_comb
  begin
    flashAddr  = addr_q;
    flashDqOut = {8'h00, cmdFor(op_q, step_q)};
    flashDqOe  = state_q == S_WR;
    flashWeN   = !(state_q == S_WR);
    flashOeN   = !(state_q == S_RD);
    flashCeN   = !(state_q == S_WR || state_q == S_RD);
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_q <= 16'h0000;
      sync2_q <= 16'h0000;
    end
    else if (clkEn)
    begin
      sync1_q <= flashDqIn;
      sync2_q <= sync1_q;
    end
  end

  // ==========================================================
  // Suspension tracking
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      suspActive_q <= 1'b0;
      suspBlock_q  <= 22'h000000;
    end
    else if (clkEn)
    begin
      if (state_q == S_SAMP && op_q == OP_SUSPEND && sync2_q[SR_READY_BIT])
      begin
        suspActive_q <= sync2_q[SR_SUSP_BIT];
        suspBlock_q  <= blockOf(22'(addr_q));
      end
      else if (state_q == S_DONE && op_q == OP_RESUME)
        suspActive_q <= 1'b0;
    end
  end

  // ==========================================================
  // Answer
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      respValid <= 1'b0;
      resp      <= '0;
    end
    else if (clkEn)
    begin
      respValid <= state_q == S_DONE;
      if (state_q == S_SAMP)
      begin
        resp.data       <= sync2_q;
        resp.ready      <= sync2_q[SR_READY_BIT];
        resp.suspended  <= sync2_q[SR_SUSP_BIT];
        resp.locked     <= sync2_q[BSR_LOCK_BIT];
        resp.lockedDown <= sync2_q[BSR_LDOWN_BIT];
        // Query byte valid only with zero high byte; BLOCK_LOCK_STATE with zero spare bits
        resp.queryOk    <= (op_q == OP_READ_QUERY)
                           ? sync2_q[15:8] == QUERY_HI_ZERO
                           : (op_q == OP_READ_BSR)
                             ? sync2_q[7:2] == BSR_RSVD_ZERO
                             : 1'b1;
      end
    end
  end
endmodule

// [verif/flash_host_ctrl_props.sv]
// Port checker for the flash host controller.
// Bound into every flash_host_ctrl instance.
module flash_host_ctrl_props
  import flash_host_pkg::*;
(
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        reqValid,
  input wire req_t        req,
  input wire logic        reqReady,
  input wire logic        suspendRefused,
  input wire logic [21:0] flashAddr,
  input wire logic [15:0] flashDqOut,
  input wire logic        flashDqOe,
  input wire logic        flashCeN,
  input wire logic        flashOeN,
  input wire logic        flashWeN
);
  timeunit 1ns;
  timeprecision 1ns;
  logic take;
  assign take = reqValid && reqReady && !suspendRefused;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_wr(logic [7:0] c);
    !flashWeN && flashDqOut[7:0] == c;
  endsequence
  property p_susp;
    take && req.op == OP_SUSPEND |=> s_wr(CMD_SUSPEND);
  endproperty
  property p_stat;
    take && req.op == OP_SUSPEND |-> ##3 s_wr(CMD_READ_STATUS);
  endproperty
  property p_arr;
    take && req.op == OP_READ_ARRAY |=> s_wr(CMD_READ_ARRAY);
  endproperty
  property p_res;
    take && req.op == OP_RESUME |=> s_wr(CMD_RESUME);
  endproperty
  property p_qry;
    take && req.op == OP_READ_QUERY |=> s_wr(CMD_READ_QUERY);
  endproperty
  property p_sts;
    take && req.op == OP_READ_STATUS |=> s_wr(CMD_READ_STATUS);
  endproperty
  // Block status read must land two words past the block base
  property p_bsr;
    take && req.op == OP_READ_BSR |=> !flashWeN && flashDqOut[7:0] == CMD_READ_CONFIG
      && flashAddr == (($past(req.addr) & ~(BLOCK_WORDS - 22'h000001)) + BSR_OFS);
  endproperty
  property p_pulse;
    $fell(flashOeN) |=> !flashOeN [*3] ##1 flashOeN;
  endproperty
  property p_rd;
    !flashOeN |-> !flashDqOe && !flashCeN && flashWeN;
  endproperty
  property p_ref;
    suspendRefused |-> reqReady ##1 (flashWeN && flashCeN);
  endproperty
  a_susp: assert property (p_susp) else $error("suspend write missing");
  a_stat: assert property (p_stat) else $error("status write missing");
  a_arr: assert property (p_arr) else $error("array write missing");
  a_res: assert property (p_res) else $error("resume write missing");
  a_qry: assert property (p_qry) else $error("query write missing");
  a_sts: assert property (p_sts) else $error("status command missing");
  a_bsr: assert property (p_bsr) else $error("block status access wrong");
  a_pulse: assert property (p_pulse) else $error("read strobe length");
  a_rd: assert property (p_rd) else $error("read strobe clash");
  a_ref: assert property (p_ref) else $error("refused order ran");
endmodule
bind flash_host_ctrl flash_host_ctrl_props u_props (.clock, .nrst, .reqValid, .req, .reqReady,
  .suspendRefused, .flashAddr, .flashDqOut, .flashDqOe, .flashCeN, .flashOeN, .flashWeN);

// [verif/flash_model.sv]
// Behavioural word-wide flash device for the host controller.
// Commands latch on the write strobe's rising edge.
module flash_model
  import flash_host_pkg::*;
#(
  parameter int          SLOW = 2,
  parameter logic [15:0] PTR  = 16'h0035
)(
  input  wire logic [21:0] addr,
  input  wire logic [15:0] dq,
  input  wire logic        ceN,
  input  wire logic        oeN,
  input  wire logic        weN,
  output logic      [15:0] q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  cmd = 8'hFF;
  logic [15:0] sts = 16'h0080;
  logic [15:0] last = 16'h0000;
  logic [15:0] f;
  logic        susp = 1'b0;
  int          busy = 0;
  function automatic logic [7:0] qb(input logic [7:0] a);
    case (a)
      8'h10: return QRY_CHAR_Q;
      8'h11: return QRY_CHAR_R;
      8'h12: return QRY_CHAR_Y;
      8'h15: return PTR[7:0];
      8'h16: return PTR[15:8];
      8'h1B: return 8'h27;
      default: return 8'h00;
    endcase
  endfunction
  always @(posedge weN)
  begin
    cmd = dq[7:0];
    busy = (cmd == CMD_SUSPEND) ? SLOW : busy;
    susp = (cmd == CMD_SUSPEND) || (susp && cmd != CMD_RESUME);
  end
  // Status only refreshes on a new read strobe
  always @(negedge oeN)
  begin
    sts = {8'h00, busy == 0, 4'h0, susp && busy == 0, 2'b00};
    busy = (busy > 0) ? busy - 1 : 0;
  end
  always @*
  begin
    case (cmd)
      CMD_SUSPEND, CMD_READ_STATUS: f = sts;
      CMD_READ_QUERY: f = {QUERY_HI_ZERO, qb(addr[7:0])};
      CMD_READ_CONFIG: f = (addr[14:0] == 15'h0002) ?
        {14'h0, addr[21:15] == 7'h02, addr[21:15] != 7'h00} : 16'h0000;
      default: f = addr[15:0] ^ 16'h5A5A;
    endcase
    if (!ceN && !oeN)
      last = f;
  end
  // Released bus shows the inverse, never a stale match
  assign q = (!ceN && !oeN) ? f : ~last;
endmodule

// [verif/testbench.sv]
// Testbench for the flash host controller.
// Drives orders at the falling edge; the model answers at the pins.
module testbench import flash_host_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0, nrst = 1'b0, reqValid = 1'b0, clkEn = 1'b1;
  logic        reqReady, respValid, suspendRefused, flashDqOe, flashCeN, flashOeN, flashWeN;
  logic [21:0] flashAddr;
  logic [15:0] flashDqIn, flashDqOut;
  req_t        req = '0;
  resp_t       resp;
  int          fail_count = 0, n_tests = 0;
  logic [7:0]  qa [5] = '{8'h10, 8'h11, 8'h12, 8'h15, 8'h16};
  logic [7:0]  qe [5] = '{QRY_CHAR_Q, QRY_CHAR_R, QRY_CHAR_Y, 8'h35, 8'h00};
  flash_host_ctrl uut (.clock, .nrst, .clkEn, .reqValid, .req, .reqReady, .respValid,
    .resp, .suspendRefused, .flashAddr, .flashDqIn, .flashDqOut, .flashDqOe, .flashCeN,
    .flashOeN, .flashWeN);
  flash_model dev (.addr(flashAddr), .dq(flashDqOut), .ceN(flashCeN), .oeN(flashOeN),
    .weN(flashWeN), .q(flashDqIn));
  initial forever #50 clock = ~clock;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task waitResp;
    int n;
    n = 0;
    while (respValid !== 1'b1 && n < 300)
    begin
      @(negedge clock);
      n++;
    end
    chk({15'h0, n < 300}, 16'h0001);
  endtask
  task run(input op_t o, input logic [21:0] a);
    @(negedge clock);
    reqValid = 1'b1;
    req = '{op: o, addr: a};
    @(negedge clock);
    reqValid = 1'b0;
    waitResp;
  endtask
  task test_done;
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clock);
    @(negedge clock) nrst = 1'b1;
    run(OP_SUSPEND, 22'h008010);
    chk(resp.data, 16'h0084);
    chk({14'h0, resp.ready, resp.suspended}, 16'h0003);
    @(negedge clock);
    reqValid = 1'b1;
    req = '{op: OP_READ_ARRAY, addr: 22'h008005};
    #1 chk({15'h0, suspendRefused}, 16'h0001);
    @(negedge clock) reqValid = 1'b0;
    run(OP_READ_ARRAY, 22'h010003);
    for (int i = 0; i < 5; i++)
    begin
      run(OP_READ_QUERY, {14'h0, qa[i]});
      chk(resp.data, {QUERY_HI_ZERO, qe[i]});
      chk({15'h0, resp.queryOk}, 16'h0001);
    end
    for (int b = 0; b < 3; b++)
    begin
      run(OP_READ_BSR, {b[6:0], 15'h0000});
      chk(resp.data, {14'h0, b == 2, b != 0});
      chk({13'h0, resp.locked, resp.lockedDown, resp.queryOk}, {13'h0, b != 0, b == 2, 1'b1});
    end
    run(OP_RESUME, 22'h000000);
    // Parked block is readable again once resumed
    @(negedge clock);
    reqValid = 1'b1;
    req = '{op: OP_READ_ARRAY, addr: 22'h008005};
    #1 chk({15'h0, suspendRefused}, 16'h0000);
    @(negedge clock);
    reqValid = 1'b0;
    waitResp;
    run(OP_READ_STATUS, 22'h000000);
    chk(resp.data, 16'h0080);
    // ==========================================================
    // Clock enable low must hold the write strobe where it is
    @(negedge clock);
    reqValid = 1'b1;
    req = '{op: OP_READ_STATUS, addr: 22'h000000};
    @(negedge clock);
    reqValid = 1'b0;
    clkEn = 1'b0;
    repeat (4) @(negedge clock) chk({14'h0, flashWeN, reqReady}, 16'h0000);
    clkEn = 1'b1;
    waitResp;
    chk(resp.data, 16'h0080);
    test_done;
  end
  initial
  begin
    #1000000;
    fail_count++;
    test_done;
  end
endmodule
